// File: inc/lfeoc_defs.svh
`ifndef LFEOC_DEFS_SVH
`define LFEOC_DEFS_SVH

// ==========================================
// register addresses
`define LFEOC_ADDR_LF_CTRL     8'h86
`define LFEOC_ADDR_EXT_CTRL    8'hB1

// ==========================================
// low_freq_osc_control fields
`define LFEOC_LF_EN_BIT        7
`define LFEOC_LF_RDY_BIT       6
`define LFEOC_LF_TUNE_MSB      5
`define LFEOC_LF_TUNE_LSB      2
`define LFEOC_LF_DIV_MSB       1
`define LFEOC_LF_DIV_LSB       0
`define LFEOC_LF_DIV_RESET     2'h0

// ==========================================
// ext_osc_control fields
`define LFEOC_X_VLD_BIT        7
`define LFEOC_X_MODE_MSB       6
`define LFEOC_X_MODE_LSB       4
`define LFEOC_X_FCN_MSB        2
`define LFEOC_X_FCN_LSB        0
`define LFEOC_X_FCN_RESET      3'h0

// ==========================================
// timing
`define LFEOC_CLK_KHZ          100000
`define LFEOC_LF_NOM_KHZ       80
`define LFEOC_LF_HALF_CYC      (`LFEOC_CLK_KHZ / (2 * `LFEOC_LF_NOM_KHZ))
`define LFEOC_LF_TUNE_STEP     11'h014
`define LFEOC_LF_SETTLE        4'h8
`define LFEOC_X_VLD_EDGES      8'h20
`define LFEOC_X_TIMEOUT        16'h2710

`endif

// File: inc/lfeoc_pkg.sv
package lfeoc_pkg;

	// ==========================================
	// external oscillator modes
	typedef enum logic [2:0] {
		LFEOC_XM_OFF0      = 3'h0,
		LFEOC_XM_OFF1      = 3'h1,
		LFEOC_XM_CMOS      = 3'h2,
		LFEOC_XM_CMOS_DIV2 = 3'h3,
		LFEOC_XM_RC        = 3'h4,
		LFEOC_XM_CAP       = 3'h5,
		LFEOC_XM_XTAL      = 3'h6,
		LFEOC_XM_XTAL_DIV2 = 3'h7
	} lfeoc_xmode_e;

	// ==========================================
	// low-frequency oscillator state
	typedef struct packed {
		logic [10:0] half_cnt;
		logic        raw;
		logic [2:0]  div_cnt;
		logic        out;
		logic        rise;
		logic        fall;
		logic [3:0]  settle;
		logic        ready;
	} lfeoc_lf_s;

	// ==========================================
	// capture state
	typedef struct packed {
		logic [1:0][15:0] reload;
		logic [1:0]       pulse;
	} lfeoc_cap_s;

	// ==========================================
	// top-level state
	typedef struct packed {
		logic         lf_en;
		logic [3:0]   lf_tune;
		logic [1:0]   lf_div;
		logic         lf_div_chg;
		lfeoc_xmode_e xmode;
		logic [2:0]   ext_freq_control;
		logic [1:0]   pin_s1;
		logic [1:0]   pin_s2;
		logic         ext_prev;
		logic         ext_div2;
		logic         ext_out;
		logic         ext_tick;
		logic [7:0]   edge_cnt;
		logic [15:0]  idle_cnt;
		logic         valid;
		logic [7:0]   rdata;
		logic         p02_used;
		logic         p03_used;
		logic         p03_out;
		logic         p03_oe;
	} lfeoc_top_s;

endpackage

// File: core/lfeoc_lf_osc.sv
`timescale 1ns/10ps
`include "lfeoc_defs.svh"

module lfeoc_lf_osc (
	input  wire logic       ref_clk,     // system clock
	input  wire logic       rst,         // sync reset
	input  wire logic       enable,      // oscillator enable
	input  wire logic [3:0] fine_tune,   // 0 fastest, 15 slowest
	input  wire logic [1:0] div_sel,     // output divider code
	input  wire logic       div_chg,     // divider code changed
	output logic            lf_out,      // divided output level
	output logic            lf_rise,     // rising edge pulse
	output logic            lf_fall,     // falling edge pulse
	output logic            ready        // frequency settled
);
	import lfeoc_pkg::*;

	lfeoc_lf_s st_r;
	lfeoc_lf_s st_nxt;
	logic [10:0] half_len;

	// half period: nominal plus slower steps per tune code
	assign half_len = 11'(`LFEOC_LF_HALF_CYC) + 11'(fine_tune) * `LFEOC_LF_TUNE_STEP;

	// ==========================================
	// oscillator core and divider
	always_comb begin
		st_nxt = st_r;
		st_nxt.rise = 1'b0;
		st_nxt.fall = 1'b0;
		if (!enable) begin
			st_nxt.half_cnt = 11'h000;
			st_nxt.raw = 1'b0;
			st_nxt.div_cnt = 3'h0;
			st_nxt.out = 1'b0;
		end else if (st_r.half_cnt >= half_len - 11'h001) begin
			st_nxt.half_cnt = 11'h000;
			st_nxt.raw = ~st_r.raw;
			if (!st_r.raw)
				st_nxt.div_cnt = st_r.div_cnt + 3'h1;
			if (st_r.settle != `LFEOC_LF_SETTLE)
				st_nxt.settle = st_r.settle + 4'h1;
		end else begin
			st_nxt.half_cnt = st_r.half_cnt + 11'h001;
		end
		// 00 /8, 01 /4, 10 /2, 11 /1
		unique case (div_sel)
			2'h0: st_nxt.out = enable & st_nxt.div_cnt[2];
			2'h1: st_nxt.out = enable & st_nxt.div_cnt[1];
			2'h2: st_nxt.out = enable & st_nxt.div_cnt[0];
			2'h3: st_nxt.out = st_nxt.raw;
		endcase
		st_nxt.rise = st_nxt.out & ~st_r.out;
		st_nxt.fall = ~st_nxt.out & st_r.out;
		// ready clears only on divider change
		if (div_chg) begin
			st_nxt.settle = 4'h0;
			st_nxt.ready = 1'b0;
		end else if (st_nxt.settle == `LFEOC_LF_SETTLE) begin
			st_nxt.ready = 1'b1;
		end
	end

	// state register
	always_ff @(posedge ref_clk) begin
		if (rst)
			st_r <= '0;
		else
			st_r <= st_nxt;
	end

	assign lf_out = st_r.out;
	assign lf_rise = st_r.rise;
	assign lf_fall = st_r.fall;
	assign ready = st_r.ready;

endmodule // lfeoc_lf_osc

// File: core/lfeoc_capture.sv
`timescale 1ns/10ps

module lfeoc_capture (
	input  wire logic        ref_clk,      // system clock
	input  wire logic        rst,          // sync reset
	input  wire logic [1:0]  cap_mode,     // [0] timer 2, [1] timer 3
	input  wire logic        lf_rise,      // oscillator rising edge
	input  wire logic        lf_fall,      // oscillator falling edge
	input  wire logic [15:0] tmr2_count,   // timer 2 count bytes
	input  wire logic [15:0] tmr3_count,   // timer 3 count bytes
	output logic [15:0]      tmr2_reload,  // timer 2 reload bytes
	output logic [15:0]      tmr3_reload,  // timer 3 reload bytes
	output logic             tmr2_capture, // timer 2 capture pulse
	output logic             tmr3_capture  // timer 3 capture pulse
);
	import lfeoc_pkg::*;

	lfeoc_cap_s       st_r;
	lfeoc_cap_s       st_nxt;
	logic [1:0]       hit;
	logic [1:0][15:0] count;
	logic [1:0]       edge_sel;

	assign count[0] = tmr2_count;
	assign count[1] = tmr3_count;
	// timer 2 on falling, timer 3 on rising
	assign edge_sel = {lf_rise, lf_fall};

	// ==========================================
	// per-timer capture
	genvar i;
	generate
		for (i = 0; i < 2; i++) begin : g_ch
			assign hit[i] = cap_mode[i] & edge_sel[i];
		end
	endgenerate

	// copy count into reload on capture
	always_comb begin
		st_nxt = st_r;
		st_nxt.pulse = hit;
		for (int k = 0; k < 2; k++) begin
			if (hit[k])
				st_nxt.reload[k] = count[k];
		end
	end

	// state register
	always_ff @(posedge ref_clk) begin
		if (rst)
			st_r <= '0;
		else
			st_r <= st_nxt;
	end

	assign tmr2_reload = st_r.reload[0];
	assign tmr3_reload = st_r.reload[1];
	assign tmr2_capture = st_r.pulse[0];
	assign tmr3_capture = st_r.pulse[1];

endmodule // lfeoc_capture

// File: core/lfeoc_top.sv
`timescale 1ns/10ps
`include "lfeoc_defs.svh"

module lfeoc_top #(
	parameter logic [15:0] EXT_TIMEOUT = `LFEOC_X_TIMEOUT // idle cycles before valid drops
) (
	input  wire logic        ref_clk,       // 100 MHz system clock
	input  wire logic        rst,           // sync reset, active high
	input  wire logic [3:0]  factory_trim,  // factory fine-tune value
	input  wire logic [7:0]  sfr_addr,      // register address
	input  wire logic [7:0]  sfr_wdata,     // write data
	input  wire logic        sfr_wr,        // write strobe
	input  wire logic        sfr_rd,        // read strobe
	output logic [7:0]       sfr_rdata,     // read data
	input  wire logic        p0_2_in,       // crystal_pin_in pin level
	input  wire logic        p0_3_in,       // crystal_pin_out pin level
	output logic             p0_3_out,      // crystal drive level
	output logic             p0_3_oe,       // crystal drive enable
	output logic             p0_2_used,     // pin held by oscillator
	output logic             p0_3_used,     // pin held by oscillator
	output logic             ext_osc_out,   // external clock for system
	output logic             ext_osc_tick,  // external clock edge pulse
	output logic             lf_osc_out,    // divided low-frequency clock
	input  wire logic [1:0]  tmr_cap_mode,  // capture mode, timer 2 and 3
	input  wire logic [15:0] tmr2_count,    // timer 2 count bytes
	input  wire logic [15:0] tmr3_count,    // timer 3 count bytes
	output logic [15:0]      tmr2_reload,   // timer 2 reload bytes
	output logic [15:0]      tmr3_reload,   // timer 3 reload bytes
	output logic             tmr2_capture,  // timer 2 capture pulse
	output logic             tmr3_capture   // timer 3 capture pulse
);
	import lfeoc_pkg::*;

	lfeoc_top_s st_r;
	lfeoc_top_s st_nxt;
	logic       lf_ready;
	logic       lf_rise;
	logic       lf_fall;
	logic       wr_lf;
	logic       wr_ext;
	logic       xtal_mode;
	logic       cmos_mode;
	logic       ext_active;
	logic       div2_mode;
	logic       ext_src;
	logic       ext_rise;

	// ==========================================
	// register decode
	assign wr_lf = sfr_wr & (sfr_addr == `LFEOC_ADDR_LF_CTRL);
	assign wr_ext = sfr_wr & (sfr_addr == `LFEOC_ADDR_EXT_CTRL);

	// mode classes
	assign xtal_mode = (st_r.xmode == LFEOC_XM_XTAL) | (st_r.xmode == LFEOC_XM_XTAL_DIV2);
	assign cmos_mode = (st_r.xmode == LFEOC_XM_CMOS) | (st_r.xmode == LFEOC_XM_CMOS_DIV2);
	assign ext_active = st_r.xmode[2] | st_r.xmode[1];
	assign div2_mode = (st_r.xmode == LFEOC_XM_CMOS_DIV2) | (st_r.xmode == LFEOC_XM_XTAL_DIV2);

	// oscillation sensed on P0.2 for crystal, P0.3 otherwise
	assign ext_src = xtal_mode ? st_r.pin_s2[0] : st_r.pin_s2[1];
	assign ext_rise = ext_active & ext_src & ~st_r.ext_prev;

	// ==========================================
	// next-state logic
	always_comb begin
		st_nxt = st_r;
		st_nxt.lf_div_chg = 1'b0;
		st_nxt.ext_tick = 1'b0;

		// pin synchronisers
		st_nxt.pin_s1 = {p0_3_in, p0_2_in};
		st_nxt.pin_s2 = st_r.pin_s1;

		// low-frequency control writes
		if (wr_lf) begin
			st_nxt.lf_en = sfr_wdata[`LFEOC_LF_EN_BIT];
			st_nxt.lf_tune = sfr_wdata[`LFEOC_LF_TUNE_MSB:`LFEOC_LF_TUNE_LSB];
			st_nxt.lf_div = sfr_wdata[`LFEOC_LF_DIV_MSB:`LFEOC_LF_DIV_LSB];
			st_nxt.lf_div_chg = (sfr_wdata[`LFEOC_LF_DIV_MSB:`LFEOC_LF_DIV_LSB] != st_r.lf_div);
		end

		// external control writes; bit 3 and bit 7 ignored
		if (wr_ext) begin
			st_nxt.xmode = lfeoc_xmode_e'(sfr_wdata[`LFEOC_X_MODE_MSB:`LFEOC_X_MODE_LSB]);
			st_nxt.ext_freq_control = sfr_wdata[`LFEOC_X_FCN_MSB:`LFEOC_X_FCN_LSB];
		end

		// pin ownership and crystal drive
		st_nxt.p02_used = xtal_mode;
		st_nxt.p03_used = ext_active;
		st_nxt.p03_oe = xtal_mode;
		st_nxt.p03_out = xtal_mode & ~st_r.pin_s2[0];

		// external clock path, raw or halved
		st_nxt.ext_prev = ext_active & ext_src;
		if (!ext_active) begin
			st_nxt.ext_div2 = 1'b0;
			st_nxt.ext_out = 1'b0;
		end else begin
			if (ext_rise)
				st_nxt.ext_div2 = ~st_r.ext_div2;
			st_nxt.ext_out = div2_mode ? st_nxt.ext_div2 : ext_src;
			st_nxt.ext_tick = div2_mode ? (ext_rise & ~st_r.ext_div2) : ext_rise;
		end

		// valid detector: enough edges, no long gap
		if (!ext_active || cmos_mode) begin
			st_nxt.edge_cnt = 8'h00;
			st_nxt.idle_cnt = 16'h0000;
			st_nxt.valid = 1'b0;
		end else if (ext_rise) begin
			st_nxt.idle_cnt = 16'h0000;
			if (st_r.edge_cnt != `LFEOC_X_VLD_EDGES)
				st_nxt.edge_cnt = st_r.edge_cnt + 8'h01;
			if (st_nxt.edge_cnt == `LFEOC_X_VLD_EDGES)
				st_nxt.valid = 1'b1;
		end else if (st_r.idle_cnt >= EXT_TIMEOUT) begin
			st_nxt.edge_cnt = 8'h00;
			st_nxt.valid = 1'b0;
		end else begin
			st_nxt.idle_cnt = st_r.idle_cnt + 16'h0001;
		end

		// read data, held until the next read
		if (sfr_rd) begin
			unique case (sfr_addr)
				`LFEOC_ADDR_LF_CTRL:
					st_nxt.rdata = {st_r.lf_en, lf_ready, st_r.lf_tune, st_r.lf_div};
				`LFEOC_ADDR_EXT_CTRL:
					st_nxt.rdata = {st_r.valid, st_r.xmode, 1'b0, st_r.ext_freq_control};
				default:
					st_nxt.rdata = 8'h00;
			endcase
		end
	end

	// ==========================================
	// state register; trim caught at reset
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			st_r <= '0;
			st_r.lf_tune <= factory_trim;
			st_r.lf_div <= `LFEOC_LF_DIV_RESET;
			st_r.ext_freq_control <= `LFEOC_X_FCN_RESET;
		end else begin
			st_r <= st_nxt;
		end
	end

	// ==========================================
	// low-frequency oscillator
	lfeoc_lf_osc u_lf (
		.ref_clk   (ref_clk),
		.rst       (rst),
		.enable    (st_r.lf_en),
		.fine_tune (st_r.lf_tune),
		.div_sel   (st_r.lf_div),
		.div_chg   (st_r.lf_div_chg),
		.lf_out    (lf_osc_out),
		.lf_rise   (lf_rise),
		.lf_fall   (lf_fall),
		.ready     (lf_ready)
	);

	// timer capture of oscillator edges
	lfeoc_capture u_cap (
		.ref_clk      (ref_clk),
		.rst          (rst),
		.cap_mode     (tmr_cap_mode),
		.lf_rise      (lf_rise),
		.lf_fall      (lf_fall),
		.tmr2_count   (tmr2_count),
		.tmr3_count   (tmr3_count),
		.tmr2_reload  (tmr2_reload),
		.tmr3_reload  (tmr3_reload),
		.tmr2_capture (tmr2_capture),
		.tmr3_capture (tmr3_capture)
	);

	// ==========================================
	// outputs from state flops
	assign sfr_rdata = st_r.rdata;
	assign p0_3_out = st_r.p03_out;
	assign p0_3_oe = st_r.p03_oe;
	assign p0_2_used = st_r.p02_used;
	assign p0_3_used = st_r.p03_used;
	assign ext_osc_out = st_r.ext_out;
	assign ext_osc_tick = st_r.ext_tick;

endmodule // lfeoc_top

// File: tb/lfeoc_chk.sv
`timescale 1ns/10ps
`include "lfeoc_defs.svh"

module lfeoc_chk #(
	parameter logic [15:0] EXT_TIMEOUT = `LFEOC_X_TIMEOUT // idle limit, unused here
) (
	input wire logic        ref_clk,      // clock
	input wire logic        rst,          // sync reset
	input wire logic [7:0]  sfr_addr,     // address
	input wire logic        sfr_rd,       // read strobe
	input wire logic [7:0]  sfr_rdata,    // read data
	input wire logic        p0_2_used,    // pin held
	input wire logic        p0_3_used,    // pin held
	input wire logic        p0_3_oe,      // drive enable
	input wire logic        p0_2_in,      // first pin level
	input wire logic        p0_3_out,     // drive level
	input wire logic        ext_osc_out,  // external clock
	input wire logic        ext_osc_tick, // edge pulse
	input wire logic        lf_osc_out,   // lf clock
	input wire logic [1:0]  tmr_cap_mode, // capture modes
	input wire logic [15:0] tmr2_count,   // timer 2
	input wire logic [15:0] tmr3_count,   // timer 3
	input wire logic [15:0] tmr2_reload,  // reload 2
	input wire logic [15:0] tmr3_reload,  // reload 3
	input wire logic        tmr2_capture, // pulse 2
	input wire logic        tmr3_capture  // pulse 3
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);

	// ==========================================
	// capture steps
	sequence s_fall2;
		$fell(lf_osc_out) && tmr_cap_mode[0];
	endsequence
	sequence s_rise3;
		$rose(lf_osc_out) && tmr_cap_mode[1];
	endsequence

	// ==========================================
	// assertions
	a_rdata_hold: assert property (!sfr_rd |=> $stable(sfr_rdata))
		else $error("read data moved without a read");
	a_unmapped_zero: assert property (sfr_rd && sfr_addr != 8'h86 && sfr_addr != 8'hB1 |=> sfr_rdata == 8'h00)
		else $error("unmapped read not zero");
	a_pin_xtal: assert property (p0_2_used |-> p0_3_used)
		else $error("crystal pin pair incomplete");
	a_drive_xtal: assert property (p0_3_oe == p0_2_used)
		else $error("crystal drive enable wrong");
	a_tick_pulse: assert property (ext_osc_tick |=> !ext_osc_tick)
		else $error("tick longer than one cycle");
	a_cap2_fall: assert property (s_fall2 |=> tmr2_capture && tmr2_reload == $past(tmr2_count))
		else $error("timer 2 capture missing");
	a_cap3_rise: assert property (s_rise3 |=> tmr3_capture && tmr3_reload == $past(tmr3_count))
		else $error("timer 3 capture missing");
	a_cap2_cause: assert property (tmr2_capture |->
		$past(lf_osc_out, 2) && !$past(lf_osc_out) && $past(tmr_cap_mode[0]))
		else $error("timer 2 capture without falling edge");
	a_cap3_cause: assert property (tmr3_capture |->
		!$past(lf_osc_out, 2) && $past(lf_osc_out) && $past(tmr_cap_mode[1]))
		else $error("timer 3 capture without rising edge");
	a_reload_hold: assert property (!tmr3_capture |-> $stable(tmr3_reload))
		else $error("timer 3 reload moved");
	a_drive_invert: assert property (p0_3_oe |-> p0_3_out == !$past(p0_2_in, 3))
		else $error("crystal drive not inverse of first pin");
	a_tick_level: assert property (ext_osc_tick |-> ext_osc_out)
		else $error("tick without external clock high");
endmodule // lfeoc_chk

bind lfeoc_top lfeoc_chk #(.EXT_TIMEOUT(EXT_TIMEOUT)) u_lfeoc_chk (.ref_clk, .rst, .sfr_addr, .sfr_rd,
	.sfr_rdata, .p0_2_used, .p0_3_used, .p0_3_oe, .p0_2_in, .p0_3_out, .ext_osc_out, .ext_osc_tick,
	.lf_osc_out, .tmr_cap_mode, .tmr2_count,
	.tmr3_count, .tmr2_reload, .tmr3_reload, .tmr2_capture, .tmr3_capture);

// File: tb/lfeoc_xtal_model.sv
`timescale 1ns/10ps

module lfeoc_xtal_model #(
	parameter int HALF = 7 // half period in clock cycles
) (
	input wire logic ref_clk,  // bench clock
	input wire logic run,      // oscillation on
	input wire logic p0_3_out, // device drive
	input wire logic p0_3_oe,  // device drive enable
	output logic     p0_2_in,  // first pin
	output logic     p0_3_in   // second pin
);
	logic osc = 1'b0;
	int   n   = 0;

	// crystal swings only while running, frozen otherwise
	always @(posedge ref_clk) begin
		if (run) begin
			n <= (n == HALF - 1) ? 0 : n + 1;
			if (n == HALF - 1) begin
				osc <= !osc;
			end
		end
	end

	// second pin follows the device drive when enabled
	assign p0_2_in = osc;
	assign p0_3_in = p0_3_oe ? p0_3_out : osc;
endmodule // lfeoc_xtal_model

// File: tb/tb_top.sv
`timescale 1ns/10ps
`include "lfeoc_defs.svh"

module tb_top;
	localparam logic [3:0] TRIM = 4'hA;
	localparam int         HALF = `LFEOC_LF_HALF_CYC;
	logic        ref_clk = 1'b0, rst = 1'b1, sfr_wr = 1'b0, sfr_rd = 1'b0, run = 1'b0;
	logic [7:0]  sfr_addr = 8'h00, sfr_wdata = 8'h00, sfr_rdata, d;
	logic [1:0]  tmr_cap_mode = 2'h0;
	logic [15:0] tmr2_count = 16'h0000, tmr3_count, tmr2_reload, tmr3_reload, r0;
	logic        p0_2_in, p0_3_in, p0_3_out, p0_3_oe, p0_2_used, p0_3_used;
	logic        ext_osc_out, ext_osc_tick, lf_osc_out, tmr2_capture, tmr3_capture;
	int          err_count = 0, comparisons = 0, n;
	time         t0, t1;

	// clock and free-running timers
	always #5 ref_clk = ~ref_clk;
	always @(posedge ref_clk) tmr2_count <= tmr2_count + 16'h0001;
	assign tmr3_count = ~tmr2_count;

	lfeoc_top #(.EXT_TIMEOUT(16'h00C8)) u_lfeoc_top (.ref_clk, .rst, .factory_trim(TRIM), .sfr_addr,
		.sfr_wdata, .sfr_wr, .sfr_rd, .sfr_rdata, .p0_2_in, .p0_3_in, .p0_3_out, .p0_3_oe, .p0_2_used,
		.p0_3_used, .ext_osc_out, .ext_osc_tick, .lf_osc_out, .tmr_cap_mode, .tmr2_count, .tmr3_count,
		.tmr2_reload, .tmr3_reload, .tmr2_capture, .tmr3_capture);
	lfeoc_xtal_model u_lfeoc_xtal_model (.ref_clk, .run, .p0_3_out, .p0_3_oe, .p0_2_in, .p0_3_in);

	// ==========================================
	// tasks
	task chk(input logic [15:0] seen, input logic [15:0] exp);
		comparisons++;
		if (seen !== exp) begin
			err_count++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task wr(input logic [7:0] a, input logic [7:0] v);
		@(posedge ref_clk);
		sfr_addr <= a;
		sfr_wdata <= v;
		sfr_wr <= 1'b1;
		@(posedge ref_clk);
		sfr_wr <= 1'b0;
	endtask
	task rd(input logic [7:0] a, output logic [7:0] v);
		@(posedge ref_clk);
		sfr_addr <= a;
		sfr_rd <= 1'b1;
		@(posedge ref_clk);
		sfr_rd <= 1'b0;
		#1 v = sfr_rdata;
	endtask
	task per(output int p);
		@(posedge lf_osc_out);
		t0 = $time;
		@(posedge lf_osc_out);
		p = int'((($time - t0) / 10));
	endtask
	task cyc(input int k);
		repeat (k) @(posedge ref_clk);
	endtask
	task close_out;
		$display("errors=%0d comparisons=%0d", err_count, comparisons);
		if (err_count == 0 && comparisons > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	// ==========================================
	// main sequence
	initial begin
		cyc(4);
		rst <= 1'b0;
		rd(8'h86, d); chk(d, {2'b00, TRIM, 2'b00});
		rd(8'hB1, d); chk(d, 16'h0000);
		wr(8'h55, 8'hFF); rd(8'h55, d); chk(d, 16'h0000);
		rd(8'h86, d); chk(d, {2'b00, TRIM, 2'b00});
		wr(8'h86, 8'hC3); rd(8'h86, d); chk(d, 16'h0083);
		per(n); per(n); chk(16'(n), 16'(2 * HALF));
		cyc(1500); rd(8'h86, d); chk(d, 16'h00C3);
		wr(8'h86, 8'hBF); rd(8'h86, d); chk(d, 16'h00FF);
		per(n); per(n); chk(16'(n), 16'(2 * (HALF + 15 * `LFEOC_LF_TUNE_STEP)));
		@(posedge ref_clk) tmr_cap_mode <= 2'h3;
		@(posedge tmr2_capture) #1 r0 = tmr2_reload;
		chk(lf_osc_out, 16'h0000);
		@(posedge tmr2_capture) #1 chk(tmr2_reload - r0, 16'(n));
		@(posedge tmr3_capture) #1 r0 = tmr3_reload;
		chk(lf_osc_out, 16'h0001);
		@(posedge tmr3_capture) #1 chk(r0 - tmr3_reload, 16'(n));
		@(posedge ref_clk) tmr_cap_mode <= 2'h0;
		for (int i = 0; i < 3; i++) begin
			wr(8'h86, 8'h80 | 8'(2 - i)); rd(8'h86, d); chk(d[6], 16'h0000);
			per(n); per(n); chk(16'(n), 16'((2 * HALF) << (i + 1)));
		end
		wr(8'h86, 8'h00); rd(8'h86, d); chk(d, 16'h0040);
		cyc(1000); #1 chk(lf_osc_out, 16'h0000);
		@(posedge ref_clk) run <= 1'b1;
		for (int m = 0; m < 8; m++) begin
			wr(8'hB1, {1'b1, 3'(m), 1'b1, 3'h5}); cyc(700); rd(8'hB1, d);
			chk(d, {m >= 4, 3'(m), 1'b0, 3'h5});
			chk({p0_2_used, p0_3_used, p0_3_oe}, {m >= 6, m >= 2, m >= 6});
		end
		@(posedge ext_osc_out) t0 = $time;
		@(negedge ext_osc_out) t1 = $time;
		@(posedge ext_osc_out) chk(16'(t1 - t0), 16'($time - t1));
		@(posedge ref_clk) run <= 1'b0;
		cyc(400); rd(8'hB1, d); chk(d[7], 16'h0000);
		close_out;
	end

	// watchdog against a hang
	initial begin
		#1200000;
		err_count++;
		close_out;
	end
endmodule // tb_top
